// ---- ceits_pkg.sv ----
// Purpose: constants for condition select and if-then state logic
// Assumes: 4-bit condition codes, 8-bit if-then state
// Notes: flag order in vectors is n, z, c, v (bit 3 down to 0)
package ceits_pkg;

  // ************************************************
  // condition codes and state
  // ************************************************
  localparam logic [3:0] COND_ALWAYS = 4'he;
  localparam logic [3:0] COND_NEVER_ALIAS = 4'hf;
  localparam logic [7:0] STATE_RESET = 8'h00;
  localparam logic [3:0] LAST_SLOT_CODE = 4'h8;

  // base condition selectors, condition bits 3:1
  localparam logic [2:0] BASE_EQ = 3'h0;
  localparam logic [2:0] BASE_CS = 3'h1;
  localparam logic [2:0] BASE_MI = 3'h2;
  localparam logic [2:0] BASE_VS = 3'h3;
  localparam logic [2:0] BASE_HI = 3'h4;
  localparam logic [2:0] BASE_GE = 3'h5;
  localparam logic [2:0] BASE_GT = 3'h6;
  localparam logic [2:0] BASE_AL = 3'h7;

  // flag bit positions
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;

endpackage

// ---- ceits_cond_exec.sv ----
// Purpose: active condition select, predicate evaluation and if-then state update
// Assumes: pipeline gives one instruction decision per cycle on the same clock
// Notes: state loads on block entry, steps on normal completion of a block instruction
`timescale 1ns/1ps

// Function
// [RULE1] self-conditioned branch uses its own 4-bit condition field
// [RULE2] otherwise, nonzero low state nibble selects state bits 7:4 as condition
// [RULE3] state all zero and no self-conditioned branch gives always-execute 1110
// [RULE4] base result: 000 zero, 001 carry, 010 negative, 011 overflow
// [RULE5] 100 carry and not zero; 101 n equals v; 110 also zero clear; 111 true
// [RULE6] invert base result when condition bit 0 set, except for 1111
// [RULE7] conditions 111x always execute regardless of flags
// [RULE8] undefined instruction failing its condition is a no-op, no exception
// [RULE9] branch with own condition 1110 is undefined unless block check fails
// [RULE10] state bits 7:5 hold base condition top bits, zero outside a block
// [RULE11] bits 4:0 hold per-slot low bits; size from lowest set bit; zero outside
// [RULE12] entry low-field lowest one at bit 0..3 marks block of four..one
// [RULE13] condition low bit set to one selects inverse of base condition
// [RULE14] if-then instruction loads state from its condition and then/else pattern
// [RULE15] state advances when a block instruction completes normally
// [RULE16] advance clears all if bits 2:0 zero, else shifts 4:0 left, keeps 7:5
// [RULE17] branching final-slot instruction leaves state in normal execution
// [RULE18] last-of-block flag exactly when state bits 3:0 equal 1000
// [RULE19] state is an 8-bit register resetting to all zeros
module ceits_cond_exec
  import ceits_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // flags
  input wire logic [3:0] programFlagsReg,
  // decode
  input wire logic branchOwnCond,
  input wire logic [3:0] branchCondField,
  input wire logic undefinedInstr,
  // if-then instruction
  input wire logic itLoad,
  input wire logic [3:0] itFirstCond,
  input wire logic [3:0] itMask,
  // completion
  input wire logic instrComplete,
  input wire logic instrBranched,
  // results
  output logic [3:0] activeConditionSelect,
  output logic executePredicate,
  output logic undefinedException,
  output logic finalSlotTest,
  output logic inBlock,
  output logic [7:0] ifThenState
);

  // ************************************************
  // evaluation function
  // ************************************************
  function automatic logic cond_eval(input logic [3:0] cond, input logic [3:0] fl);
    logic base;
    base = 1'b0;
    unique case (cond[3:1])
      BASE_EQ: base = fl[FLAG_Z]; // RULE4
      BASE_CS: base = fl[FLAG_C]; // RULE4
      BASE_MI: base = fl[FLAG_N]; // RULE4
      BASE_VS: base = fl[FLAG_V]; // RULE4
      BASE_HI: base = fl[FLAG_C] && !fl[FLAG_Z]; // RULE5
      BASE_GE: base = (fl[FLAG_N] == fl[FLAG_V]); // RULE5
      BASE_GT: base = (fl[FLAG_N] == fl[FLAG_V]) && !fl[FLAG_Z]; // RULE5
      BASE_AL: base = 1'b1; // RULE5 RULE7
    endcase
    if (cond[0] && (cond != COND_NEVER_ALIAS)) begin
      base = !base; // RULE6 RULE13
    end
    return base;
  endfunction

  // ************************************************
  // condition select and predicate
  // ************************************************
  logic [7:0] stateQ;
  logic [7:0] stateD;
  logic condPass;
  logic blockPass;

  always_comb begin
    if (branchOwnCond) begin
      activeConditionSelect = branchCondField; // RULE1
    end else if (stateQ[3:0] != 4'h0) begin
      activeConditionSelect = stateQ[7:4]; // RULE2 RULE13
    end else begin
      activeConditionSelect = COND_ALWAYS; // RULE3
    end
  end

  assign condPass = cond_eval(activeConditionSelect, programFlagsReg);
  assign inBlock = (stateQ[3:0] != 4'h0);
  // enclosing block check, which alone can mask a branch with condition 1110
  assign blockPass = inBlock ? cond_eval(stateQ[7:4], programFlagsReg) : 1'b1; // RULE9
  // a failing undefined instruction is suppressed like any other
  assign executePredicate = condPass; // RULE8
  assign undefinedException = (condPass && undefinedInstr) || // RULE8
    (branchOwnCond && branchCondField == COND_ALWAYS && blockPass); // RULE9
  assign finalSlotTest = (stateQ[3:0] == LAST_SLOT_CODE); // RULE18
  assign ifThenState = stateQ;

  // ************************************************
  // state update
  // ************************************************
  always_comb begin
    stateD = stateQ;
    if (itLoad && !inBlock) begin
      if (itMask == 4'h0) begin
        stateD = STATE_RESET;
      end else begin
        stateD = {itFirstCond, itMask}; // RULE14 RULE10 RULE11 RULE12
      end
    end else if (instrComplete && inBlock) begin
      if (instrBranched || stateQ[2:0] == 3'h0) begin
        stateD = STATE_RESET; // RULE16 RULE17
      end else begin
        stateD = {stateQ[7:5], stateQ[3:0], 1'b0}; // RULE15 RULE16
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stateQ <= STATE_RESET; // RULE19
    end else begin
      stateQ <= stateD;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  sequence s_in_block_done;
    instrComplete && inBlock && !itLoad;
  endsequence

  sequence s_block_entry;
    itLoad && !inBlock && itMask != 4'h0;
  endsequence

  sequence s_zero_entry;
    itLoad && !inBlock && itMask == 4'h0;
  endsequence

  sequence s_bad_branch;
    branchOwnCond && branchCondField == COND_ALWAYS;
  endsequence

  chk_always_cond: assert property (@(posedge clk) disable iff (reset) // RULE7
    activeConditionSelect[3:1] == 3'h7 |-> executePredicate)
    else $error("111x condition did not pass");
  chk_invert_bit: assert property (@(posedge clk) disable iff (reset) // RULE6
    (activeConditionSelect[3:1] != 3'h7 && activeConditionSelect[0]) |->
    (cond_eval({activeConditionSelect[3:1], 1'b0}, programFlagsReg) != executePredicate))
    else $error("odd condition not inverse of even");
  chk_own_cond: assert property (@(posedge clk) disable iff (reset) // RULE1
    branchOwnCond |-> activeConditionSelect == branchCondField)
    else $error("branch field not selected");
  chk_idle_always: assert property (@(posedge clk) disable iff (reset) // RULE3
    (!branchOwnCond && stateQ == 8'h00) |-> activeConditionSelect == COND_ALWAYS)
    else $error("idle condition not always");
  chk_state_cond: assert property (@(posedge clk) disable iff (reset) // RULE2
    (!branchOwnCond && inBlock) |-> activeConditionSelect == stateQ[7:4])
    else $error("block condition not from state");
  chk_step_shift: assert property (@(posedge clk) disable iff (reset) // RULE16
    s_in_block_done ##0 (!instrBranched && stateQ[2:0] != 3'h0) |=>
    stateQ == {$past(stateQ[7:5]), $past(stateQ[3:0]), 1'b0})
    else $error("advance shift wrong");
  chk_step_clear: assert property (@(posedge clk) disable iff (reset) // RULE16
    s_in_block_done ##0 (stateQ[2:0] == 3'h0) |=> stateQ == 8'h00)
    else $error("advance did not clear");
  chk_branch_exit: assert property (@(posedge clk) disable iff (reset) // RULE17
    s_in_block_done ##0 instrBranched |=> !inBlock && stateQ[7:5] == 3'h0)
    else $error("branch left block active");
  chk_last_flag: assert property (@(posedge clk) disable iff (reset) // RULE18
    finalSlotTest == (ifThenState[3:0] == 4'h8))
    else $error("last slot flag wrong");
  chk_bad_branch: assert property (@(posedge clk) disable iff (reset) // RULE9
    s_bad_branch ##0 blockPass |-> undefinedException)
    else $error("branch with 1110 did not fault");
  chk_branch_masked: assert property (@(posedge clk) disable iff (reset) // RULE9
    s_bad_branch ##0 (!undefinedInstr && !blockPass) |-> !undefinedException)
    else $error("masked 1110 branch faulted");
  chk_undef_pass: assert property (@(posedge clk) disable iff (reset) // RULE8
    (undefinedInstr && executePredicate) |-> undefinedException)
    else $error("passing undefined did not fault");
  chk_fault_cause: assert property (@(posedge clk) disable iff (reset) // RULE8
    undefinedException |-> undefinedInstr || (branchOwnCond && branchCondField == 4'he))
    else $error("fault without cause");
  chk_undef_nop: assert property (@(posedge clk) disable iff (reset) // RULE8
    !executePredicate |-> !undefinedException)
    else $error("failed instruction raised fault");
  chk_load_state: assert property (@(posedge clk) disable iff (reset) // RULE14
    (itLoad && !inBlock && itMask != 4'h0) |=> stateQ == {$past(itFirstCond), $past(itMask)})
    else $error("block entry load wrong");
  chk_idle_top: assert property (@(posedge clk) disable iff (reset) // RULE10 RULE11
    !inBlock |-> stateQ == 8'h00)
    else $error("idle state not zero");
  chk_zero_mask: assert property (@(posedge clk) disable iff (reset) // RULE14
    s_zero_entry |=> stateQ == 8'h00)
    else $error("empty mask left state");
  chk_entry_active: assert property (@(posedge clk) disable iff (reset) // RULE12
    s_block_entry |=> inBlock)
    else $error("entry did not start block");
  chk_load_refused: assert property (@(posedge clk) disable iff (reset) // RULE14
    (itLoad && inBlock && !instrComplete) |=> stateQ == $past(stateQ))
    else $error("load inside block changed state");
  chk_state_hold: assert property (@(posedge clk) disable iff (reset) // RULE15
    (!itLoad && !(instrComplete && inBlock)) |=> stateQ == $past(stateQ))
    else $error("state moved without event");
  chk_base_hold: assert property (@(posedge clk) disable iff (reset) // RULE10
    s_in_block_done |=> stateQ == 8'h00 || stateQ[7:5] == $past(stateQ[7:5]))
    else $error("base condition changed in block");
  chk_last_exit: assert property (@(posedge clk) disable iff (reset) // RULE18
    s_in_block_done ##0 finalSlotTest |=> stateQ == 8'h00)
    else $error("last slot did not end block");
  chk_slot_low: assert property (@(posedge clk) disable iff (reset) // RULE13
    (inBlock && !branchOwnCond) |-> activeConditionSelect[0] == stateQ[4])
    else $error("slot low bit not used");
  chk_in_block: assert property (@(posedge clk) disable iff (reset) // RULE11
    inBlock == (ifThenState[3:0] != 4'h0))
    else $error("in block flag wrong");
  chk_state_out: assert property (@(posedge clk) disable iff (reset) // RULE19
    ifThenState == stateQ)
    else $error("state output differs");

  // ************************************************
  // condition code table
  // ************************************************
  chk_code_zero_set: assert property (@(posedge clk) disable iff (reset) // RULE4
    activeConditionSelect == 4'h0 |->
    executePredicate == programFlagsReg[FLAG_Z])
    else $error("code 0000 mismatch");
  chk_code_zero_clr: assert property (@(posedge clk) disable iff (reset) // RULE6
    activeConditionSelect == 4'h1 |->
    executePredicate == !programFlagsReg[FLAG_Z])
    else $error("code 0001 mismatch");
  chk_code_carry_set: assert property (@(posedge clk) disable iff (reset) // RULE4
    activeConditionSelect == 4'h2 |->
    executePredicate == programFlagsReg[FLAG_C])
    else $error("code 0010 mismatch");
  chk_code_carry_clr: assert property (@(posedge clk) disable iff (reset) // RULE6
    activeConditionSelect == 4'h3 |->
    executePredicate == !programFlagsReg[FLAG_C])
    else $error("code 0011 mismatch");
  chk_code_neg_set: assert property (@(posedge clk) disable iff (reset) // RULE4
    activeConditionSelect == 4'h4 |->
    executePredicate == programFlagsReg[FLAG_N])
    else $error("code 0100 mismatch");
  chk_code_neg_clr: assert property (@(posedge clk) disable iff (reset) // RULE6
    activeConditionSelect == 4'h5 |->
    executePredicate == !programFlagsReg[FLAG_N])
    else $error("code 0101 mismatch");
  chk_code_ovf_set: assert property (@(posedge clk) disable iff (reset) // RULE4
    activeConditionSelect == 4'h6 |->
    executePredicate == programFlagsReg[FLAG_V])
    else $error("code 0110 mismatch");
  chk_code_ovf_clr: assert property (@(posedge clk) disable iff (reset) // RULE6
    activeConditionSelect == 4'h7 |->
    executePredicate == !programFlagsReg[FLAG_V])
    else $error("code 0111 mismatch");
  chk_code_higher: assert property (@(posedge clk) disable iff (reset) // RULE5
    activeConditionSelect == 4'h8 |->
    executePredicate == (programFlagsReg[FLAG_C] && !programFlagsReg[FLAG_Z]))
    else $error("code 1000 mismatch");
  chk_code_lower_same: assert property (@(posedge clk) disable iff (reset) // RULE6
    activeConditionSelect == 4'h9 |->
    executePredicate == (!programFlagsReg[FLAG_C] || programFlagsReg[FLAG_Z]))
    else $error("code 1001 mismatch");
  chk_code_sign_ge: assert property (@(posedge clk) disable iff (reset) // RULE5
    activeConditionSelect == 4'ha |->
    executePredicate == (programFlagsReg[FLAG_N] == programFlagsReg[FLAG_V]))
    else $error("code 1010 mismatch");
  chk_code_sign_lt: assert property (@(posedge clk) disable iff (reset) // RULE6
    activeConditionSelect == 4'hb |->
    executePredicate == (programFlagsReg[FLAG_N] != programFlagsReg[FLAG_V]))
    else $error("code 1011 mismatch");
  chk_code_sign_gt: assert property (@(posedge clk) disable iff (reset) // RULE5
    activeConditionSelect == 4'hc |-> executePredicate ==
    (!programFlagsReg[FLAG_Z] && programFlagsReg[FLAG_N] == programFlagsReg[FLAG_V]))
    else $error("code 1100 mismatch");
  chk_code_sign_le: assert property (@(posedge clk) disable iff (reset) // RULE6
    activeConditionSelect == 4'hd |-> executePredicate ==
    (programFlagsReg[FLAG_Z] || programFlagsReg[FLAG_N] != programFlagsReg[FLAG_V]))
    else $error("code 1101 mismatch");
  chk_code_always: assert property (@(posedge clk) disable iff (reset) // RULE7
    activeConditionSelect == 4'he |->
    executePredicate)
    else $error("code 1110 did not pass");
  chk_code_alias: assert property (@(posedge clk) disable iff (reset) // RULE7
    activeConditionSelect == 4'hf |->
    executePredicate)
    else $error("code 1111 did not pass");

endmodule

// ---- ceits_pipe_model.sv ----
// Purpose: pipeline model giving block entry and completion events
// Assumes: one instruction event per clock
// Notes: drives just after the rising edge
`timescale 1ns/1ps
module ceits_pipe_model (
  // clock
  input wire logic clk,
  // instruction events
  output logic itLoad,
  output logic [3:0] itFirstCond,
  output logic [3:0] itMask,
  output logic instrComplete,
  output logic instrBranched
);
  initial {itLoad, itFirstCond, itMask, instrComplete, instrBranched} = '0;
  // one event per call, outputs hold the last event's values between calls
  task automatic issue(input logic l, input logic [3:0] c, m, input logic d, b);
    @(posedge clk);
    itLoad <= l;
    itFirstCond <= c;
    itMask <= m;
    instrComplete <= d;
    instrBranched <= b;
  endtask
endmodule

// ---- test_cond_exec_if_then_state.sv ----
// Purpose: self-checking bench for condition select and if-then state
// Assumes: 250 MHz clock, async active-high reset
// Notes: outputs sampled at the falling edge
`timescale 1ns/1ps
module test_cond_exec_if_then_state import ceits_pkg::*;;
  logic clk = 0, reset = 1, bOwn = 0, undef = 0, exc, pred, fin, inBlk, ld, cp, br;
  logic [3:0] flags = 0, bField = 0, sel, fc, mk;
  logic [7:0] st;
  int nErrors = 0, samplesChecked = 0, cycles = 0;
  ceits_pipe_model pm (.clk(clk), .itLoad(ld), .itFirstCond(fc), .itMask(mk),
    .instrComplete(cp), .instrBranched(br));
  ceits_cond_exec DUT (.clk(clk), .reset(reset), .programFlagsReg(flags),
    .branchOwnCond(bOwn), .branchCondField(bField), .undefinedInstr(undef),
    .itLoad(ld), .itFirstCond(fc), .itMask(mk), .instrComplete(cp), .instrBranched(br),
    .activeConditionSelect(sel), .executePredicate(pred), .undefinedException(exc),
    .finalSlotTest(fin), .inBlock(inBlk), .ifThenState(st));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      nErrors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic passOf(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = (f[3] == f[0]) & ~f[2];
      default: r = 1'b1;
    endcase
    return (c[0] && c != 4'hf) ? ~r : r;
  endfunction
  task automatic condTable();
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 16; f++) begin
        @(posedge clk);
        bOwn <= 1;
        bField <= 4'(c);
        flags <= 4'(f);
        undef <= f[0];
        @(negedge clk);
        check(8'(sel), 8'(c));
        check(8'(pred), 8'(passOf(4'(c), 4'(f))));
        check(8'(exc), 8'(passOf(4'(c), 4'(f)) & (f[0] | c == 14)));
      end
    end
    @(posedge clk);
    bOwn <= 0;
    undef <= 0;
    @(negedge clk);
    check(8'(sel), 8'(COND_ALWAYS));
    $display("condTable done");
  endtask
  task automatic blockWalk(input logic [3:0] c, input logic [3:0] m, input int brAt);
    logic [7:0] s;
    logic a;
    s = {c, m};
    pm.issue(1, c, m, 0, 0);
    for (int i = 0; i < 6; i++) begin
      a = s[3:0] != 0;
      pm.issue(a, ~c, 4'h1, a, a && i == brAt);
      @(negedge clk);
      check(st, s);
      check(8'(fin), 8'(s[3:0] == LAST_SLOT_CODE));
      check(8'(inBlk), 8'(a));
      check(8'(sel), 8'(a ? s[7:4] : COND_ALWAYS));
      check(8'(pred), 8'(passOf(a ? s[7:4] : COND_ALWAYS, flags)));
      if (a) s = (i == brAt || s[2:0] == 0) ? 8'h00 : {s[7:5], s[3:0], 1'b0};
    end
    $display("blockWalk done");
  endtask
  task automatic maskedBranch();
    pm.issue(1, 4'h0, 4'h8, 0, 0);
    pm.issue(0, 4'h0, 4'h0, 0, 0);
    bOwn <= 1;
    bField <= COND_ALWAYS;
    flags <= 4'h0;
    @(negedge clk);
    check(8'(exc), 8'h00);
    @(posedge clk);
    flags <= 4'h4;
    @(negedge clk);
    check(8'(exc), 8'h01);
    pm.issue(0, 4'h0, 4'h0, 1, 0);
    bOwn <= 0;
    pm.issue(0, 4'h0, 4'h0, 0, 0);
    @(negedge clk);
    check(st, 8'h00);
    $display("maskedBranch done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 0;
    @(negedge clk);
    check(st, 8'h00);
    condTable();
    maskedBranch();
    blockWalk(4'h1, 4'h7, 9);
    blockWalk(4'h4, 4'ha, 9);
    blockWalk(4'hb, 4'hc, 9);
    blockWalk(4'hd, 4'h8, 9);
    blockWalk(4'h2, 4'h4, 1);
    results();
  end
endmodule
